// *** src/image_format_roi_control.sv ***
// image format slots, region of interest, summing, skipping, mirror, pixel format
`timescale 1ns/1ps
module image_format_roi_control #(
	parameter bit COLOUR_VARIANT = 1'b0,
	parameter bit LARGE_SENSOR   = 1'b0
) (
	// clock, reset, enable
	input  wire logic                              i_clk_sys,
	input  wire logic                              i_rst_n,
	input  wire logic                              i_ce,
	// axi4-lite write
	input  wire logic [image_fmt_pkg::ADDR_W-1:0] i_awaddr,
	input  wire logic                              i_awvalid,
	output logic                                   o_awready,
	input  wire logic [31:0]                       i_wdata,
	input  wire logic [3:0]                        i_wstrb,
	input  wire logic                              i_wvalid,
	output logic                                   o_wready,
	output logic [1:0]                             o_bresp,
	output logic                                   o_bvalid,
	input  wire logic                              i_bready,
	// axi4-lite read
	input  wire logic [image_fmt_pkg::ADDR_W-1:0] i_araddr,
	input  wire logic                              i_arvalid,
	output logic                                   o_arready,
	output logic [31:0]                            o_rdata,
	output logic [1:0]                             o_rresp,
	output logic                                   o_rvalid,
	input  wire logic                              i_rready,
	// acquisition path
	input  wire logic                              i_stream_active,
	input  wire logic [image_fmt_pkg::DIM_W-1:0]  i_line_idx,
	// active configuration
	output logic [image_fmt_pkg::DIM_W-1:0]       o_roi_width,
	output logic [image_fmt_pkg::DIM_W-1:0]       o_roi_height,
	output logic [image_fmt_pkg::DIM_W-1:0]       o_roi_horiz_start,
	output logic [image_fmt_pkg::DIM_W-1:0]       o_roi_vert_start,
	output logic [2:0]                             o_horiz_sum_factor,
	output logic [2:0]                             o_vert_sum_factor,
	output logic [2:0]                             o_horiz_skip_factor,
	output logic [2:0]                             o_vert_skip_factor,
	output logic                                   o_mirror_horiz,
	output logic                                   o_mirror_vert,
	output logic [1:0]                             o_mosaic_order,
	output logic [2:0]                             o_pixel_coding_select,
	output logic [2:0]                             o_pixel_bit_depth,
	output logic                                   o_pixel_byte_order,
	output logic [31:0]                            o_output_format_id,
	output logic                                   o_line_fast
);
	import image_fmt_pkg::*;

	// ------------------------------------------------------------
	// variant limits
	// ------------------------------------------------------------
	localparam logic [11:0] MAX_W = LARGE_SENSOR ? MAX_W_LARGE : MAX_W_SMALL;
	localparam logic [11:0] MAX_H = LARGE_SENSOR ? MAX_H_LARGE : MAX_H_SMALL;
	localparam logic [2:0]  RST_CODE  = COLOUR_VARIANT ? CODE_RGB : CODE_MONO;
	localparam logic [2:0]  RST_DEPTH = COLOUR_VARIANT ? DEPTH_24 : DEPTH_8;

	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	logic              awready_q, awready_d, wready_q, wready_d;
	logic              bvalid_q, bvalid_d, arready_q, arready_d;
	logic              rvalid_q, rvalid_d;
	logic [1:0]        bresp_q, bresp_d, rresp_q, rresp_d;
	logic [7:0]        awaddr_q, awaddr_d;
	logic [31:0]       wdata_q, wdata_d, rdata_q, rdata_d;
	logic [3:0]        wstrb_q, wstrb_d;
	logic [1:0]        slot_q, slot_d;
	logic [11:0]       wid_q [0:SLOTS-1];
	logic [11:0]       wid_d [0:SLOTS-1];
	logic [11:0]       hgt_q [0:SLOTS-1];
	logic [11:0]       hgt_d [0:SLOTS-1];
	logic [11:0]       hs_q [0:SLOTS-1];
	logic [11:0]       hs_d [0:SLOTS-1];
	logic [11:0]       vs_q [0:SLOTS-1];
	logic [11:0]       vs_d [0:SLOTS-1];
	logic [2:0]        hsum_q [0:SLOTS-1];
	logic [2:0]        hsum_d [0:SLOTS-1];
	logic [2:0]        vsum_q [0:SLOTS-1];
	logic [2:0]        vsum_d [0:SLOTS-1];
	logic [2:0]        hskip_q [0:SLOTS-1];
	logic [2:0]        hskip_d [0:SLOTS-1];
	logic [2:0]        vskip_q [0:SLOTS-1];
	logic [2:0]        vskip_d [0:SLOTS-1];
	logic              mh_q, mh_d, mv_q, mv_d, order_q, order_d;
	logic [2:0]        code_q, code_d, depth_q, depth_d;
	logic [31:0]       fmt_q, fmt_d;
	logic              reject_q, reject_d;
	logic [11:0]       a_wid_q, a_hgt_q, a_hs_q, a_vs_q;
	logic [2:0]        a_hsum_q, a_vsum_q, a_hskip_q, a_vskip_q;
	logic              fast_q, fast_d;
	logic              wr_en, ok, lock;
	logic [31:0]       wv, mask;
	logic [11:0]       v12;
	logic [12:0]       lim_sum;

	// ------------------------------------------------------------
	// decoding helpers
	// ------------------------------------------------------------
	function automatic logic is_mapped(input logic [7:0] a);
		return (a[1:0] == 2'h0) && (a <= OFS_STATUS);
	endfunction : is_mapped

	function automatic logic fact_ok(input logic [31:0] v);
		return (v == 32'(FACT_1)) || (v == 32'(FACT_2)) || (v == 32'(FACT_4)); // RQ9 RQ12
	endfunction : fact_ok

	function automatic logic [31:0] pix_id(input logic [2:0] c, input logic [2:0] d);
		logic [31:0] id;
		id = ID_NONE;
		if (c == CODE_MONO) begin // RQ17
			if (d == DEPTH_8) begin
				id = ID_MONO8;
			end else if (d == DEPTH_10 && !COLOUR_VARIANT) begin
				id = ID_MONO10;
			end else if (d == DEPTH_12 && !COLOUR_VARIANT) begin
				id = ID_MONO12;
			end
		end else if (COLOUR_VARIANT) begin // RQ18
			if (c == CODE_BAYER && d == DEPTH_8) id = ID_BAYER8;
			if (c == CODE_BAYER && d == DEPTH_10) id = ID_BAYER10;
			if (c == CODE_BAYER && d == DEPTH_12) id = ID_BAYER12;
			if (c == CODE_YUV411 && d == DEPTH_12) id = ID_YUV411;
			if (c == CODE_YUV422 && d == DEPTH_16) id = ID_YUV422;
			if (c == CODE_RGB && d == DEPTH_24) id = ID_RGB8;
			if (c == CODE_BGR && d == DEPTH_24) id = ID_BGR8;
		end
		return id;
	endfunction : pix_id

	function automatic logic [31:0] rd_word(input logic [7:0] a);
		logic [31:0] r;
		r = 32'h0;
		case (a)
			OFS_SLOT:   r = {30'h0, slot_q};
			OFS_WIDTH:  r = {20'h0, wid_q[slot_q]};
			OFS_HEIGHT: r = {20'h0, hgt_q[slot_q]};
			OFS_HSTART: r = {20'h0, hs_q[slot_q]};
			OFS_VSTART: r = {20'h0, vs_q[slot_q]};
			OFS_HSUM:   r = {29'h0, hsum_q[slot_q]};
			OFS_VSUM:   r = {29'h0, vsum_q[slot_q]};
			OFS_HSKIP:  r = {29'h0, hskip_q[slot_q]};
			OFS_VSKIP:  r = {29'h0, vskip_q[slot_q]};
			OFS_MIRROR: r = {30'h0, mv_q, mh_q};
			OFS_CODING: r = {29'h0, code_q};
			OFS_DEPTH:  r = {29'h0, depth_q};
			OFS_ORDER:  r = {31'h0, order_q};
			OFS_FMTID:  r = fmt_q; // RQ16
			OFS_STATUS: r = {28'h0, mv_q, mh_q, reject_q, i_stream_active};
			default:    r = 32'h0;
		endcase
		return r;
	endfunction : rd_word

	// ------------------------------------------------------------
	// bus slave
	// ------------------------------------------------------------
	assign wr_en = !awready_q && !wready_q && !bvalid_q;

	always_comb begin
		awready_d = awready_q;
		wready_d  = wready_q;
		bvalid_d  = bvalid_q;
		bresp_d   = bresp_q;
		awaddr_d  = awaddr_q;
		wdata_d   = wdata_q;
		wstrb_d   = wstrb_q;
		arready_d = arready_q;
		rvalid_d  = rvalid_q;
		rresp_d   = rresp_q;
		rdata_d   = rdata_q;
		if (awready_q && i_awvalid) begin
			awready_d = 1'b0;
			awaddr_d  = i_awaddr;
		end
		if (wready_q && i_wvalid) begin
			wready_d = 1'b0;
			wdata_d  = i_wdata;
			wstrb_d  = i_wstrb;
		end
		if (wr_en) begin
			bvalid_d = 1'b1;
			bresp_d  = is_mapped(awaddr_q) ? RESP_OKAY : RESP_SLVERR;
		end
		if (bvalid_q && i_bready) begin
			bvalid_d  = 1'b0;
			awready_d = 1'b1;
			wready_d  = 1'b1;
		end
		if (arready_q && i_arvalid) begin
			arready_d = 1'b0;
			rvalid_d  = 1'b1;
			rdata_d   = rd_word(i_araddr);
			rresp_d   = is_mapped(i_araddr) ? RESP_OKAY : RESP_SLVERR;
		end
		if (rvalid_q && i_rready) begin
			rvalid_d  = 1'b0;
			arready_d = 1'b1;
		end
	end

	always_ff @(posedge i_clk_sys) begin
		if (!i_rst_n) begin
			awready_q <= 1'b1;
			wready_q  <= 1'b1;
			bvalid_q  <= 1'b0;
			bresp_q   <= RESP_OKAY;
			awaddr_q  <= 8'h0;
			wdata_q   <= 32'h0;
			wstrb_q   <= 4'h0;
			arready_q <= 1'b1;
			rvalid_q  <= 1'b0;
			rresp_q   <= RESP_OKAY;
			rdata_q   <= 32'h0;
		end else if (i_ce) begin
			awready_q <= awready_d;
			wready_q  <= wready_d;
			bvalid_q  <= bvalid_d;
			bresp_q   <= bresp_d;
			awaddr_q  <= awaddr_d;
			wdata_q   <= wdata_d;
			wstrb_q   <= wstrb_d;
			arready_q <= arready_d;
			rvalid_q  <= rvalid_d;
			rresp_q   <= rresp_d;
			rdata_q   <= rdata_d;
		end
	end

	// ------------------------------------------------------------
	// configuration registers
	// ------------------------------------------------------------
	always_comb begin
		slot_d  = slot_q;
		wid_d   = wid_q;
		hgt_d   = hgt_q;
		hs_d    = hs_q;
		vs_d    = vs_q;
		hsum_d  = hsum_q;
		vsum_d  = vsum_q;
		hskip_d = hskip_q;
		vskip_d = vskip_q;
		mh_d    = mh_q;
		mv_d    = mv_q;
		order_d = order_q;
		code_d  = code_q;
		depth_d = depth_q;
		reject_d = reject_q;
		ok      = 1'b1;
		lock    = i_stream_active;
		mask    = {{8{wstrb_q[3]}}, {8{wstrb_q[2]}}, {8{wstrb_q[1]}}, {8{wstrb_q[0]}}};
		wv      = (rd_word(awaddr_q) & ~mask) | (wdata_q & mask);
		v12     = wv[11:0];
		lim_sum = 13'h0;
		if (wr_en && is_mapped(awaddr_q)) begin
			case (awaddr_q)
				OFS_SLOT: begin
					ok = !lock && wv <= 32'(SLOT_LAST); // RQ2 RQ1
					if (ok) slot_d = wv[1:0];
				end
				OFS_WIDTH: begin
					lim_sum = {1'b0, hs_q[slot_q]} + {1'b0, v12};
					ok = !lock && wv[31:12] == 20'h0 && v12 >= MIN_DIM // RQ8 RQ7
						&& (v12 & H_STEP_M1) == 12'h0 // RQ5
						&& lim_sum <= {1'b0, MAX_W}; // RQ21
					if (ok) wid_d[slot_q] = v12;
				end
				OFS_HEIGHT: begin
					lim_sum = {1'b0, vs_q[slot_q]} + {1'b0, v12};
					ok = !lock && wv[31:12] == 20'h0 && v12 >= MIN_DIM // RQ8 RQ7
						&& (v12 & V_STEP_M1) == 12'h0 // RQ5
						&& lim_sum <= {1'b0, MAX_H}; // RQ21
					if (ok) hgt_d[slot_q] = v12;
				end
				OFS_HSTART: begin
					lim_sum = {1'b0, wid_q[slot_q]} + {1'b0, v12};
					ok = !lock && wv[31:12] == 20'h0 // RQ8
						&& (v12 & H_STEP_M1) == 12'h0 // RQ6
						&& lim_sum <= {1'b0, MAX_W}; // RQ21
					if (ok) hs_d[slot_q] = v12;
				end
				OFS_VSTART: begin
					lim_sum = {1'b0, hgt_q[slot_q]} + {1'b0, v12};
					ok = !lock && wv[31:12] == 20'h0 // RQ8
						&& (v12 & V_STEP_M1) == 12'h0 // RQ6
						&& lim_sum <= {1'b0, MAX_H}; // RQ21
					if (ok) vs_d[slot_q] = v12;
				end
				OFS_HSUM, OFS_VSUM: begin
					ok = !lock && fact_ok(wv); // RQ11 RQ9
					if (ok && awaddr_q == OFS_HSUM) hsum_d[slot_q] = wv[2:0];
					if (ok && awaddr_q == OFS_VSUM) vsum_d[slot_q] = wv[2:0];
					if (ok && wv[2:0] != FACT_1) begin
						hskip_d[slot_q] = FACT_1; // RQ13
						vskip_d[slot_q] = FACT_1; // RQ13
					end
				end
				OFS_HSKIP, OFS_VSKIP: begin
					ok = !lock && fact_ok(wv); // RQ14 RQ12
					if (ok && awaddr_q == OFS_HSKIP) hskip_d[slot_q] = wv[2:0];
					if (ok && awaddr_q == OFS_VSKIP) vskip_d[slot_q] = wv[2:0];
					if (ok && wv[2:0] != FACT_1) begin
						hsum_d[slot_q] = FACT_1; // RQ10
						vsum_d[slot_q] = FACT_1; // RQ10
					end
				end
				OFS_MIRROR: begin
					mh_d = wv[0]; // RQ15
					mv_d = wv[1]; // RQ15
				end
				OFS_CODING: begin
					ok = pix_id(wv[2:0], depth_q) != ID_NONE && wv[31:3] == 29'h0;
					if (ok) code_d = wv[2:0];
				end
				OFS_DEPTH: begin
					ok = !lock && pix_id(code_q, wv[2:0]) != ID_NONE // RQ20
						&& wv[31:3] == 29'h0;
					if (ok) depth_d = wv[2:0];
				end
				OFS_ORDER: order_d = wv[0];
				default: ok = 1'b1;
			endcase
			reject_d = !ok;
		end
		fmt_d  = pix_id(code_d, depth_d); // RQ16
		fast_d = !(i_line_idx >= a_vs_q && i_line_idx < a_vs_q + a_hgt_q); // RQ3
	end

	always_ff @(posedge i_clk_sys) begin
		if (!i_rst_n) begin
			slot_q <= SLOT_ZERO; // RQ1
			for (int i = 0; i < SLOTS; i++) begin
				wid_q[i]   <= MAX_W; // RQ7
				hgt_q[i]   <= MAX_H; // RQ7
				hs_q[i]    <= 12'h0;
				vs_q[i]    <= 12'h0;
				hsum_q[i]  <= FACT_1; // RQ9
				vsum_q[i]  <= FACT_1;
				hskip_q[i] <= FACT_1; // RQ12
				vskip_q[i] <= FACT_1;
			end
			mh_q     <= 1'b0; // RQ15
			mv_q     <= 1'b0;
			order_q  <= 1'b0;
			code_q   <= RST_CODE; // RQ17 RQ18
			depth_q  <= RST_DEPTH;
			fmt_q    <= COLOUR_VARIANT ? ID_RGB8 : ID_MONO8;
			reject_q <= 1'b0;
			fast_q   <= 1'b0;
			a_wid_q  <= MAX_W;
			a_hgt_q  <= MAX_H;
			a_hs_q   <= 12'h0;
			a_vs_q   <= 12'h0;
			a_hsum_q <= FACT_1;
			a_vsum_q <= FACT_1;
			a_hskip_q <= FACT_1;
			a_vskip_q <= FACT_1;
		end else if (i_ce) begin
			slot_q   <= slot_d;
			wid_q    <= wid_d;
			hgt_q    <= hgt_d;
			hs_q     <= hs_d;
			vs_q     <= vs_d;
			hsum_q   <= hsum_d;
			vsum_q   <= vsum_d;
			hskip_q  <= hskip_d;
			vskip_q  <= vskip_d;
			mh_q     <= mh_d;
			mv_q     <= mv_d;
			order_q  <= order_d;
			code_q   <= code_d;
			depth_q  <= depth_d;
			fmt_q    <= fmt_d;
			reject_q <= reject_d;
			fast_q   <= fast_d;
			// one rectangle per frame from the selected slot
			a_wid_q  <= wid_d[slot_d]; // RQ4
			a_hgt_q  <= hgt_d[slot_d];
			a_hs_q   <= hs_d[slot_d];
			a_vs_q   <= vs_d[slot_d];
			a_hsum_q <= hsum_d[slot_d];
			a_vsum_q <= vsum_d[slot_d];
			a_hskip_q <= hskip_d[slot_d];
			a_vskip_q <= vskip_d[slot_d];
		end
	end

	// ------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------
	assign o_awready = awready_q;
	assign o_wready  = wready_q;
	assign o_bvalid  = bvalid_q;
	assign o_bresp   = bresp_q;
	assign o_arready = arready_q;
	assign o_rvalid  = rvalid_q;
	assign o_rresp   = rresp_q;
	assign o_rdata   = rdata_q;
	assign o_roi_width         = a_wid_q;
	assign o_roi_height        = a_hgt_q;
	assign o_roi_horiz_start   = a_hs_q;
	assign o_roi_vert_start    = a_vs_q;
	assign o_horiz_sum_factor  = a_hsum_q;
	assign o_vert_sum_factor   = a_vsum_q;
	assign o_horiz_skip_factor = a_hskip_q;
	assign o_vert_skip_factor  = a_vskip_q;
	assign o_mirror_horiz      = mh_q;
	assign o_mirror_vert       = mv_q;
	// 0 bg, 1 gb, 2 gr, 3 rg
	assign o_mosaic_order        = {mv_q, mh_q}; // RQ19
	assign o_pixel_coding_select = code_q;
	assign o_pixel_bit_depth     = depth_q;
	assign o_pixel_byte_order    = order_q;
	assign o_output_format_id    = fmt_q;
	assign o_line_fast           = fast_q;

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	default clocking cb @(posedge i_clk_sys); endclocking
	default disable iff (!i_rst_n);

	sequence s_streaming;
		i_stream_active [*2];
	endsequence

	a_slot_locked: assert property (i_stream_active |=> $stable(slot_q)) // RQ2
		else $error("format slot changed while streaming");
	a_roi_locked: assert property (s_streaming |-> $stable(o_roi_width) // RQ8
		&& $stable(o_roi_height) && $stable(o_roi_horiz_start)
		&& $stable(o_roi_vert_start))
		else $error("region changed while streaming");
	a_factor_locked: assert property (s_streaming |-> $stable(o_horiz_sum_factor) // RQ11 RQ14
		&& $stable(o_vert_sum_factor) && $stable(o_horiz_skip_factor)
		&& $stable(o_vert_skip_factor))
		else $error("factor changed while streaming");
	a_depth_locked: assert property (i_stream_active |=> $stable(depth_q)) // RQ20
		else $error("bit depth changed while streaming");
	a_width_step: assert property (o_roi_width[1:0] == 2'h0 // RQ5 RQ7
		&& o_roi_height[0] == 1'b0
		&& o_roi_width >= MIN_DIM && o_roi_height >= MIN_DIM)
		else $error("region size off step or below minimum");
	a_start_step: assert property (o_roi_horiz_start[1:0] == 2'h0 // RQ6
		&& o_roi_vert_start[0] == 1'b0)
		else $error("region start off step");
	a_fit_sensor: assert property ({1'b0, o_roi_horiz_start} + {1'b0, o_roi_width} // RQ21
		<= {1'b0, MAX_W} && {1'b0, o_roi_vert_start} + {1'b0, o_roi_height}
		<= {1'b0, MAX_H})
		else $error("region exceeds sensor");
	a_sum_skip_excl: assert property ((o_horiz_sum_factor != FACT_1 // RQ10 RQ13
		|| o_vert_sum_factor != FACT_1) |-> (o_horiz_skip_factor == FACT_1
		&& o_vert_skip_factor == FACT_1))
		else $error("summing and skipping both active");
	a_format_id: assert property (o_output_format_id != ID_NONE // RQ16
		&& o_output_format_id == pix_id(o_pixel_coding_select, o_pixel_bit_depth))
		else $error("format id disagrees with coding and depth");
	a_line_fast: assert property (i_ce && i_line_idx < o_roi_vert_start // RQ3
		&& $stable(o_roi_vert_start) |=> o_line_fast)
		else $error("line above region not skipped fast");

endmodule : image_format_roi_control

// *** src/image_fmt_pkg.sv ***
// constants for the image format and region-of-interest block
// Contract
// RQ1 - three format slots; slot zero after reset; each keeps own region and factors
// RQ2 - slot select writes ignored while stream data is output
// RQ3 - lines inside region read normally, others skipped fast; width gives no speedup
// RQ4 - exactly one rectangular region per frame, no other shapes
// RQ5 - width is minimum plus multiples of four, height minimum plus multiples of two
// RQ6 - horizontal start in steps of four, vertical start in steps of two
// RQ7 - size from 64x64 to sensor maximum; maximum after reset
// RQ8 - region size and start writes ignored while stream data is output
// RQ9 - summing factors 1, 2 or 4 per axis, default 1
// RQ10 - summing is switched off while skipping is active
// RQ11 - summing factor writes ignored while stream data is output
// RQ12 - skipping factors 1, 2 or 4 per axis, default 1
// RQ13 - skipping is switched off while summing is active
// RQ14 - skipping factor writes ignored while stream data is output
// RQ15 - two independent mirror controls, both off after reset
// RQ16 - format identifier follows coding and bit depth, read only
// RQ17 - mono variant offers mono 8, 10, 12 bits with their identifiers, 8 default
// RQ18 - colour variant offers mono8, bayer, yuv411, yuv422, rgb, bgr; rgb default; code only reaches rgb and bgr, coding and depth writes check each other
// RQ19 - bayer BG order holds only unmirrored; mirroring changes mosaic order
// RQ20 - bit depth writes ignored while stream data is output
// RQ21 - region whose start plus size exceeds sensor is refused, old values stay
package image_fmt_pkg;

	// ------------------------------------------------------------
	// sizes
	// ------------------------------------------------------------
	localparam int         DIM_W      = 12;
	localparam int         ADDR_W     = 8;
	localparam int         SLOTS      = 3;
	localparam logic [1:0] SLOT_LAST  = 2'h2;
	localparam logic [1:0] SLOT_ZERO  = 2'h0;

	// ------------------------------------------------------------
	// register byte offsets
	// ------------------------------------------------------------
	localparam logic [7:0] OFS_SLOT   = 8'h00;
	localparam logic [7:0] OFS_WIDTH  = 8'h04;
	localparam logic [7:0] OFS_HEIGHT = 8'h08;
	localparam logic [7:0] OFS_HSTART = 8'h0c;
	localparam logic [7:0] OFS_VSTART = 8'h10;
	localparam logic [7:0] OFS_HSUM   = 8'h14;
	localparam logic [7:0] OFS_VSUM   = 8'h18;
	localparam logic [7:0] OFS_HSKIP  = 8'h1c;
	localparam logic [7:0] OFS_VSKIP  = 8'h20;
	localparam logic [7:0] OFS_MIRROR = 8'h24;
	localparam logic [7:0] OFS_CODING = 8'h28;
	localparam logic [7:0] OFS_DEPTH  = 8'h2c;
	localparam logic [7:0] OFS_ORDER  = 8'h30;
	localparam logic [7:0] OFS_FMTID  = 8'h34;
	localparam logic [7:0] OFS_STATUS = 8'h38;

	// ------------------------------------------------------------
	// geometry
	// ------------------------------------------------------------
	localparam logic [11:0] MIN_DIM     = 12'h040;
	localparam logic [11:0] MAX_W_SMALL = 12'h800;
	localparam logic [11:0] MAX_H_SMALL = 12'h600;
	localparam logic [11:0] MAX_W_LARGE = 12'h990;
	localparam logic [11:0] MAX_H_LARGE = 12'h800;
	localparam logic [11:0] H_STEP_M1   = 12'h003;
	localparam logic [11:0] V_STEP_M1   = 12'h001;

	// ------------------------------------------------------------
	// factors, coding, depth
	// ------------------------------------------------------------
	localparam logic [2:0] FACT_1 = 3'h1;
	localparam logic [2:0] FACT_2 = 3'h2;
	localparam logic [2:0] FACT_4 = 3'h4;

	localparam logic [2:0] CODE_MONO  = 3'h0;
	localparam logic [2:0] CODE_BAYER = 3'h1;
	localparam logic [2:0] CODE_YUV411 = 3'h2;
	localparam logic [2:0] CODE_YUV422 = 3'h3;
	localparam logic [2:0] CODE_RGB   = 3'h4;
	localparam logic [2:0] CODE_BGR   = 3'h5;

	localparam logic [2:0] DEPTH_8  = 3'h0;
	localparam logic [2:0] DEPTH_10 = 3'h1;
	localparam logic [2:0] DEPTH_12 = 3'h2;
	localparam logic [2:0] DEPTH_16 = 3'h3;
	localparam logic [2:0] DEPTH_24 = 3'h4;

	localparam logic [31:0] ID_MONO8   = 32'h01080001;
	localparam logic [31:0] ID_MONO10  = 32'h01100003;
	localparam logic [31:0] ID_MONO12  = 32'h01100005;
	localparam logic [31:0] ID_BAYER8  = 32'h0108000b;
	localparam logic [31:0] ID_BAYER10 = 32'h0110000f;
	localparam logic [31:0] ID_BAYER12 = 32'h01100013;
	localparam logic [31:0] ID_YUV411  = 32'h020c001e;
	localparam logic [31:0] ID_YUV422  = 32'h0210001f;
	localparam logic [31:0] ID_RGB8    = 32'h02180014;
	localparam logic [31:0] ID_BGR8    = 32'h02180015;
	localparam logic [31:0] ID_NONE    = 32'h00000000;

	// ------------------------------------------------------------
	// bus answers
	// ------------------------------------------------------------
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage : image_fmt_pkg

// *** testbench/host_model.sv ***
// axi4-lite master standing in for the host
`timescale 1ns/1ps
module host_model (
	// clock
	input  wire logic        i_clk_sys,
	// write
	output logic [7:0]       o_awaddr,
	output logic             o_awvalid,
	input  wire logic        i_awready,
	output logic [31:0]      o_wdata,
	output logic             o_wvalid,
	input  wire logic        i_wready,
	input  wire logic [1:0]  i_bresp,
	input  wire logic        i_bvalid,
	output logic             o_bready,
	// read
	output logic [7:0]       o_araddr,
	output logic             o_arvalid,
	input  wire logic        i_arready,
	input  wire logic [31:0] i_rdata,
	input  wire logic [1:0]  i_rresp,
	input  wire logic        i_rvalid,
	output logic             o_rready
);
	initial begin
		{o_awvalid, o_wvalid, o_bready, o_arvalid, o_rready} = 5'h00;
		{o_awaddr, o_araddr, o_wdata} = 48'h0;
	end
	task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r,
		output bit to);
		int n;
		n = 0;
		to = 1;
		@(posedge i_clk_sys);
		{o_awaddr, o_wdata, o_awvalid, o_wvalid, o_bready} <= {a, d, 3'h7};
		while (to && n < 40) begin
			@(posedge i_clk_sys);
			n++;
			// released payload is scrambled
			if (o_awvalid && i_awready) {o_awvalid, o_awaddr} <= {1'b0, ~a};
			if (o_wvalid && i_wready) {o_wvalid, o_wdata} <= {1'b0, ~d};
			if (i_bvalid) begin
				{r, to} = {i_bresp, 1'b0};
				o_bready <= 1'b0;
			end
		end
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r,
		output bit to);
		int n;
		n = 0;
		to = 1;
		@(posedge i_clk_sys);
		{o_araddr, o_arvalid, o_rready} <= {a, 2'h3};
		while (to && n < 40) begin
			@(posedge i_clk_sys);
			n++;
			if (o_arvalid && i_arready) {o_arvalid, o_araddr} <= {1'b0, ~a};
			if (i_rvalid) begin
				{d, r, to} = {i_rdata, i_rresp, 1'b0};
				o_rready <= 1'b0;
			end
		end
	endtask : rd
endmodule : host_model

// *** testbench/tb_top.sv ***
// register-level bench for the image format block
`timescale 1ns/1ps
module tb_top;
	import image_fmt_pkg::*;
	logic i_clk_sys, i_rst_n, i_ce, i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready;
	logic i_stream_active, o_awready, o_wready, o_bvalid, o_arready, o_rvalid;
	logic [7:0] i_awaddr, i_araddr;
	logic [31:0] i_wdata, o_rdata, o_output_format_id;
	logic [3:0] i_wstrb;
	logic [1:0] o_bresp, o_rresp, o_mosaic_order;
	logic [11:0] i_line_idx, o_roi_width, o_roi_height, o_roi_horiz_start, o_roi_vert_start;
	logic [2:0] o_horiz_sum_factor, o_vert_sum_factor, o_horiz_skip_factor;
	logic [2:0] o_vert_skip_factor, o_pixel_coding_select, o_pixel_bit_depth;
	logic o_mirror_horiz, o_mirror_vert, o_pixel_byte_order, o_line_fast;
	int num_errors, total_checks;
	image_format_roi_control image_format_roi_control_inst (.*);
	host_model host_model_inst (.i_clk_sys(i_clk_sys), .o_awaddr(i_awaddr),
		.o_awvalid(i_awvalid), .i_awready(o_awready), .o_wdata(i_wdata), .o_wvalid(i_wvalid),
		.i_wready(o_wready), .i_bresp(o_bresp), .i_bvalid(o_bvalid), .o_bready(i_bready),
		.o_araddr(i_araddr), .o_arvalid(i_arvalid), .i_arready(o_arready), .i_rdata(o_rdata),
		.i_rresp(o_rresp), .i_rvalid(o_rvalid), .o_rready(i_rready));
	initial begin
		i_clk_sys = 0;
		forever #12.5 i_clk_sys = ~i_clk_sys;
	end
	task automatic summarize();
		$display("checks %0d errors %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask : summarize
	task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
		total_checks++;
		if (g !== e) begin
			num_errors++;
			$display("[ERR] %s exp %h got %h", s, e, g);
		end
	endtask : chk
	task automatic w(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		logic [1:0] r;
		bit to;
		host_model_inst.wr(a, d, r, to);
		if (to) begin
			num_errors++;
			summarize();
		end else begin
			chk("bresp", {30'h0, er}, {30'h0, r});
		end
	endtask : w
	task automatic r(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
		logic [31:0] d;
		logic [1:0] p;
		bit to;
		host_model_inst.rd(a, d, p, to);
		if (to) begin
			num_errors++;
			summarize();
		end else begin
			chk("rresp", {30'h0, er}, {30'h0, p});
			chk("rdata", e, d);
		end
	endtask : r
	initial begin
		{i_rst_n, i_stream_active, i_ce, i_line_idx, i_wstrb} = {3'h1, 12'h0, 4'hf};
		repeat (3) @(posedge i_clk_sys);
		i_rst_n <= 1;
		r(OFS_SLOT, 0, RESP_OKAY);
		r(OFS_WIDTH, 32'h800, RESP_OKAY);
		r(OFS_HSKIP, 1, RESP_OKAY);
		r(OFS_MIRROR, 0, RESP_OKAY);
		r(OFS_FMTID, ID_MONO8, RESP_OKAY);
		w(OFS_DEPTH, DEPTH_12, RESP_OKAY);
		r(OFS_FMTID, ID_MONO12, RESP_OKAY);
		chk("fmtid", ID_MONO12, o_output_format_id);
		w(OFS_DEPTH, DEPTH_16, RESP_OKAY);
		w(OFS_CODING, CODE_BAYER, RESP_OKAY);
		r(OFS_CODING, CODE_MONO, RESP_OKAY);
		w(OFS_FMTID, 0, RESP_OKAY);
		r(OFS_FMTID, ID_MONO12, RESP_OKAY);
		$display("test format done");
		w(OFS_WIDTH, 32'h42, RESP_OKAY);
		r(OFS_WIDTH, 32'h800, RESP_OKAY);
		r(OFS_STATUS, 32'h2, RESP_OKAY);
		w(OFS_WIDTH, 32'h64, RESP_OKAY);
		chk("width", 32'h64, {20'h0, o_roi_width});
		w(OFS_HSTART, 32'h7a0, RESP_OKAY);
		r(OFS_HSTART, 0, RESP_OKAY);
		w(OFS_HSTART, 32'h2, RESP_OKAY);
		r(OFS_HSTART, 0, RESP_OKAY);
		w(OFS_SLOT, 1, RESP_OKAY);
		r(OFS_WIDTH, 32'h800, RESP_OKAY);
		w(OFS_SLOT, 0, RESP_OKAY);
		w(OFS_HEIGHT, 32'h40, RESP_OKAY);
		w(OFS_VSTART, 32'h10, RESP_OKAY);
		@(posedge i_clk_sys);
		chk("line_fast", 1, {31'h0, o_line_fast});
		i_line_idx <= 12'h20;
		repeat (2) @(posedge i_clk_sys);
		chk("line_fast", 0, {31'h0, o_line_fast});
		{i_ce, i_line_idx} <= 13'h0;
		repeat (2) @(posedge i_clk_sys);
		chk("line_fast", 0, {31'h0, o_line_fast});
		i_ce <= 1;
		$display("test region done");
		i_stream_active <= 1;
		w(OFS_WIDTH, 32'h80, RESP_OKAY);
		w(OFS_SLOT, 2, RESP_OKAY);
		w(OFS_HSUM, 2, RESP_OKAY);
		w(OFS_HSKIP, 2, RESP_OKAY);
		w(OFS_DEPTH, DEPTH_8, RESP_OKAY);
		w(OFS_MIRROR, 3, RESP_OKAY);
		r(OFS_WIDTH, 32'h64, RESP_OKAY);
		r(OFS_SLOT, 0, RESP_OKAY);
		r(OFS_HSUM, 1, RESP_OKAY);
		r(OFS_HSKIP, 1, RESP_OKAY);
		r(OFS_DEPTH, DEPTH_12, RESP_OKAY);
		chk("mirror", 3, {30'h0, o_mirror_vert, o_mirror_horiz});
		chk("mosaic", 3, {30'h0, o_mosaic_order});
		i_stream_active <= 0;
		w(OFS_HSUM, 2, RESP_OKAY);
		w(OFS_VSKIP, 4, RESP_OKAY);
		r(OFS_HSUM, 1, RESP_OKAY);
		w(OFS_VSUM, 4, RESP_OKAY);
		r(OFS_VSKIP, 1, RESP_OKAY);
		chk("vsum", 4, {29'h0, o_vert_sum_factor});
		w(8'h3c, 0, RESP_SLVERR);
		r(8'h3c, 0, RESP_SLVERR);
		$display("test stream done");
		summarize();
	end
endmodule : tb_top
